//--- edfc_pkg.sv
// Shared constants for the Ethernet DMA FIFO control and status slice.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package edfc_pkg;
  // Register byte offsets.
  localparam logic [7:0] FDS_OFFSET = 8'h00;
  localparam logic [7:0] RPC_OFFSET = 8'h04;
  localparam logic [7:0] DOC_OFFSET = 8'h08;
  localparam logic [7:0] RBWP_OFFSET = 8'h0c;
  localparam logic [7:0] RRQ_OFFSET = 8'h10;
  // Field positions.
  localparam int TX_SIZE_BIT = 8;
  localparam int RX_SIZE_BIT = 0;
  localparam int RX_CONT_BIT = 0;
  localparam int FIFO_HALT_BIT = 3;
  localparam int ADDR_ERR_BIT = 2;
  localparam int NMI_HALT_BIT = 1;
  localparam int RX_REQ_BIT = 0;
  // FIFO depths in bytes.
  localparam logic [9:0] FIFO_SMALL = 10'h100;
  localparam logic [9:0] FIFO_LARGE = 10'h200;
  // Reset value of every register.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Frame-completion sequencer states.
  typedef enum logic [3:0] {
    EDFC_IDLE = 4'h1,
    EDFC_STATUS = 4'h2,
    EDFC_FETCH = 4'h4,
    EDFC_STOP = 4'h8
  } edfc_state_type;
endpackage

//--- edfc_sync.sv
// Two-flop synchroniser bank for inputs arriving from outside aclk.
// Assumes inputs are levels held for at least two clock cycles.
module edfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // A bank of no bits would leave the pin with nothing to carry it.
  if (WIDTH < 1) begin : g_bad_width
    $error("edfc_sync needs a WIDTH of at least 1");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- edfc_top.sv
// Control and status slice of an Ethernet DMA engine with AXI4-Lite access.
// Assumes the engine core reports frame, FIFO and address events as pulses
// on aclk, and that the NMI pin is asynchronous.
module edfc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nmi_pin,
  input wire logic frame_done,
  input wire logic status_written,
  input wire logic desc_fetched,
  input wire logic tx_underflow,
  input wire logic rx_overflow,
  input wire logic illegal_address,
  input wire logic [31:0] rx_write_addr,
  input wire logic rx_write_addr_valid,
  output logic [9:0] tx_fifo_depth,
  output logic [9:0] rx_fifo_depth,
  output logic receive_request,
  output logic dma_run,
  output logic status_write_req,
  output logic desc_fetch_req
);
  logic tx_fifo_size_sel;
  logic rx_fifo_size_sel;
  logic rx_continue_policy;
  logic fifo_error_halt_sel;
  logic illegal_address_flag;
  logic nmi_halted_flag;
  logic fifo_halted;
  logic [31:0] rx_buffer_write_ptr;
  logic nmi_sync;
  logic nmi_prev;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  edfc_pkg::edfc_state_type state;
  edfc_pkg::edfc_state_type next_state;

  // The NMI pin is asynchronous, so it is synchronised before use.
  edfc_sync #(.WIDTH(1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(nmi_pin),
    .sync_out(nmi_sync)
  );

  // Word-address decode shared by the read and write paths.
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == edfc_pkg::FDS_OFFSET) || (a == edfc_pkg::RPC_OFFSET)
      || (a == edfc_pkg::DOC_OFFSET) || (a == edfc_pkg::RBWP_OFFSET)
      || (a == edfc_pkg::RRQ_OFFSET);
  endfunction

  // Write handshake: address and data are latched independently.
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire nmi_rise = nmi_sync && !nmi_prev;
  wire fifo_err = tx_underflow || rx_overflow;
  wire wr_doc = do_write && (aw_addr == edfc_pkg::DOC_OFFSET);
  wire wr_fds = do_write && (aw_addr == edfc_pkg::FDS_OFFSET);
  wire wr_rpc = do_write && (aw_addr == edfc_pkg::RPC_OFFSET);
  wire wr_rrq = do_write && (aw_addr == edfc_pkg::RRQ_OFFSET);
  wire wb0 = w_data[edfc_pkg::RX_REQ_BIT];
  wire aerr_clr = wr_doc && !w_data[edfc_pkg::ADDR_ERR_BIT];
  wire nmi_clr = wr_doc && !w_data[edfc_pkg::NMI_HALT_BIT];
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= edfc_pkg::REG_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= edfc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr) ? edfc_pkg::RESP_OKAY
                                           : edfc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration bits; the wstrb of lane 0 or 1 is ignored because the two FDS
  // fields sit in separate lanes and partial writes are rare.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_fifo_size_sel <= 1'b0;
      rx_fifo_size_sel <= 1'b0;
      rx_continue_policy <= 1'b0;
      fifo_error_halt_sel <= 1'b0;
    end else begin
      if (wr_fds) begin
        tx_fifo_size_sel <= w_data[edfc_pkg::TX_SIZE_BIT];
        rx_fifo_size_sel <= w_data[edfc_pkg::RX_SIZE_BIT];
      end
      if (wr_rpc)
        rx_continue_policy <= w_data[edfc_pkg::RX_CONT_BIT];
      if (wr_doc)
        fifo_error_halt_sel <= w_data[edfc_pkg::FIFO_HALT_BIT];
    end
  end

  // Sticky flags: a hardware set in the same cycle beats a software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_address_flag <= 1'b0;
      nmi_halted_flag <= 1'b0;
      fifo_halted <= 1'b0;
      nmi_prev <= 1'b0;
    end else begin
      nmi_prev <= nmi_sync;
      if (illegal_address)
        illegal_address_flag <= 1'b1;
      else if (aerr_clr)
        illegal_address_flag <= 1'b0;
      if (nmi_rise)
        nmi_halted_flag <= 1'b1;
      else if (nmi_clr)
        nmi_halted_flag <= 1'b0;
      if (fifo_err && fifo_error_halt_sel)
        fifo_halted <= 1'b1;
      else if (wr_doc)
        fifo_halted <= 1'b0;
    end
  end

  // Frame completion: write status first, then stop or fetch onward.
  always_comb begin
    next_state = state;
    case (state)
      edfc_pkg::EDFC_IDLE:
        if (frame_done && dma_run) next_state = edfc_pkg::EDFC_STATUS;
      edfc_pkg::EDFC_STATUS:
        if (status_written)
          next_state = rx_continue_policy ? edfc_pkg::EDFC_FETCH
                                          : edfc_pkg::EDFC_STOP;
      edfc_pkg::EDFC_FETCH:
        if (desc_fetched) next_state = edfc_pkg::EDFC_IDLE;
      edfc_pkg::EDFC_STOP:
        next_state = edfc_pkg::EDFC_IDLE;
      default:
        next_state = edfc_pkg::EDFC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      state <= edfc_pkg::EDFC_IDLE;
    else
      state <= next_state;
  end

  // Receive request: software sets or clears it; the stop step clears it
  // and wins over a software write in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      receive_request <= 1'b0;
    else if (state == edfc_pkg::EDFC_STOP)
      receive_request <= 1'b0;
    else if (wr_rrq)
      receive_request <= wb0;
  end

  // Snapshot of the write address; it may trail the engine by a cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_buffer_write_ptr <= edfc_pkg::REG_RESET;
    else if (rx_write_addr_valid)
      rx_buffer_write_ptr <= rx_write_addr;
  end

  // Outputs toward the engine core.
  assign dma_run = !nmi_halted_flag && !fifo_halted;
  assign status_write_req = (state == edfc_pkg::EDFC_STATUS);
  assign desc_fetch_req = (state == edfc_pkg::EDFC_FETCH);
  assign tx_fifo_depth = tx_fifo_size_sel ? edfc_pkg::FIFO_LARGE
                                          : edfc_pkg::FIFO_SMALL;
  assign rx_fifo_depth = rx_fifo_size_sel ? edfc_pkg::FIFO_LARGE
                                          : edfc_pkg::FIFO_SMALL;

  // Read mux; reserved bits are built as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = edfc_pkg::REG_RESET;
    case (s_axi_araddr)
      edfc_pkg::FDS_OFFSET: begin
        rd_mux[edfc_pkg::TX_SIZE_BIT] = tx_fifo_size_sel;
        rd_mux[edfc_pkg::RX_SIZE_BIT] = rx_fifo_size_sel;
      end
      edfc_pkg::RPC_OFFSET:
        rd_mux[edfc_pkg::RX_CONT_BIT] = rx_continue_policy;
      edfc_pkg::DOC_OFFSET: begin
        rd_mux[edfc_pkg::FIFO_HALT_BIT] = fifo_error_halt_sel;
        rd_mux[edfc_pkg::ADDR_ERR_BIT] = illegal_address_flag;
        rd_mux[edfc_pkg::NMI_HALT_BIT] = nmi_halted_flag;
      end
      edfc_pkg::RBWP_OFFSET:
        rd_mux = rx_buffer_write_ptr;
      edfc_pkg::RRQ_OFFSET:
        rd_mux[edfc_pkg::RX_REQ_BIT] = receive_request;
      default:
        rd_mux = edfc_pkg::REG_RESET;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read channel: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= edfc_pkg::REG_RESET;
      s_axi_rresp <= edfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= addr_known(s_axi_araddr) ? edfc_pkg::RESP_OKAY
                                              : edfc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Watch that the stop step always drops the receive request.
  a_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    state == edfc_pkg::EDFC_STOP |=> !receive_request)
    else $error("receive request survived stop");
  a_cont_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == edfc_pkg::EDFC_STATUS && status_written && rx_continue_policy)
    |=> desc_fetch_req)
    else $error("no fetch after status in continue mode");
  a_fifo_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (fifo_err && fifo_error_halt_sel) |=> !dma_run)
    else $error("fifo error did not halt");
  a_fifo_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (dma_run && !fifo_error_halt_sel && !nmi_rise) |=> dma_run)
    else $error("engine stopped without cause");
  a_addr_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (illegal_address_flag && !aerr_clr) |=> illegal_address_flag)
    else $error("address flag lost");
  a_nmi_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_rise |=> (nmi_halted_flag && !dma_run))
    else $error("nmi did not halt");
  a_ptr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_write_addr_valid |=> $stable(rx_buffer_write_ptr))
    else $error("write pointer moved");
  a_depth_map: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fds |=> (tx_fifo_depth == (w_data[edfc_pkg::TX_SIZE_BIT] ?
    edfc_pkg::FIFO_LARGE : edfc_pkg::FIFO_SMALL)))
    else $error("tx depth wrong");
  a_rx_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fds |=> (rx_fifo_depth == (w_data[edfc_pkg::RX_SIZE_BIT] ?
    edfc_pkg::FIFO_LARGE : edfc_pkg::FIFO_SMALL)))
    else $error("rx depth wrong");

  // A frame seen while running must start the status step at once.
  a_frame_status: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == edfc_pkg::EDFC_IDLE && frame_done && dma_run)
    |=> status_write_req)
    else $error("frame did not start status write");

  // Stop mode has two steps after the status write: stop, then request low.
  sequence s_status_done;
    state == edfc_pkg::EDFC_STATUS && status_written && !rx_continue_policy;
  endsequence
  sequence s_stop_step;
    state == edfc_pkg::EDFC_STOP ##1 !receive_request;
  endsequence
  a_stop_after_status: assert property (@(posedge aclk) disable iff (!aresetn)
    s_status_done |=> s_stop_step)
    else $error("no stop step after status write");
endmodule

//--- edfc_core_model.sv
// Behavioural model of the engine core that serves the control slice.
// Assumes status and fetch requests are levels held until answered.
module edfc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] delay,
  input wire logic status_write_req,
  input wire logic desc_fetch_req,
  output logic status_written,
  output logic desc_fetched
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  logic done_now;
  assign done_now = status_written || desc_fetched;
  // A request is answered by a one-cycle pulse after delay + 1 cycles; the
  // counter restarts after each pulse so a lingering request is not
  // answered twice before the slice has moved on.
  always_ff @(posedge aclk) begin
    status_written <= 1'b0;
    desc_fetched <= 1'b0;
    if (!aresetn || !(status_write_req || desc_fetch_req) || done_now) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt == delay) begin
      wait_cnt <= 4'h0;
      status_written <= status_write_req;
      desc_fetched <= desc_fetch_req;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

//--- edfc_top_test.sv
// Self-checking bench for the Ethernet DMA control and status slice.
// Assumes the core model answers the slice; the bench is the bus master.
module edfc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] FDS = edfc_pkg::FDS_OFFSET;
  localparam logic [7:0] RPC = edfc_pkg::RPC_OFFSET;
  localparam logic [7:0] DOC = edfc_pkg::DOC_OFFSET;
  localparam logic [7:0] PTR = edfc_pkg::RBWP_OFFSET;
  localparam logic [7:0] RRQ = edfc_pkg::RRQ_OFFSET;
  localparam logic [1:0] OK = edfc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = edfc_pkg::RESP_SLVERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, nmi, frame_done, tx_under;
  logic rx_over, bad_addr, ptr_valid, st_wr, desc_f, st_req, desc_req;
  logic rx_req, dma_run;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ptr_in;
  logic [1:0] bresp, rresp;
  logic [9:0] tx_depth, rx_depth;
  logic [5:0] ev;
  logic [3:0] dly;
  int miscompares, n_checks;
  // Engine events are driven as one vector so a task can pulse any of them.
  assign {nmi, frame_done, tx_under, rx_over, bad_addr, ptr_valid} = ev;
  edfc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rdata(rdata),
    .s_axi_arready(arready), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .nmi_pin(nmi), .frame_done(frame_done),
    .status_written(st_wr), .desc_fetched(desc_f), .tx_underflow(tx_under),
    .rx_overflow(rx_over), .illegal_address(bad_addr),
    .rx_write_addr(ptr_in), .rx_write_addr_valid(ptr_valid),
    .tx_fifo_depth(tx_depth), .rx_fifo_depth(rx_depth),
    .receive_request(rx_req), .dma_run(dma_run),
    .status_write_req(st_req), .desc_fetch_req(desc_req));
  edfc_core_model core (.aclk(aclk), .aresetn(aresetn), .delay(dly),
    .status_write_req(st_req), .desc_fetch_req(desc_req),
    .status_written(st_wr), .desc_fetched(desc_f));
  // Free-running 10 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A wait that used up its bound ends the run as a failure.
  task automatic give_up(input int n);
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
  endtask
  // Write one word; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check(32'(bresp), 32'(r));
    give_up(n);
  endtask
  // Read one word and compare data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check(rdata, d);
    check(32'(rresp), 32'(r));
    give_up(n);
  endtask
  task automatic pulse(input logic [5:0] m, input int len);
    @(posedge aclk);
    ev <= m;
    repeat (len) @(posedge aclk);
    ev <= 6'h00;
    @(posedge aclk);
  endtask
  // One frame under the given policy, answered at the given core delay.
  task automatic s_frame(input logic p, input logic [3:0] d);
    logic sw, df;
    sw = 1'b0;
    df = 1'b0;
    dly <= d;
    wr(RPC, {31'h0, p}, OK);
    wr(RRQ, 32'h1, OK);
    check(32'(rx_req), 32'h1);
    pulse(6'h10, 1);
    repeat (30) begin
      @(posedge aclk);
      sw |= st_req;
      df |= desc_req;
    end
    check(32'(sw), 32'h1);
    check(32'(df), 32'(p));
    check(32'(rx_req), 32'(p));
    rd(RRQ, 32'(p), OK);
  endtask
  // A reset in mid-run must bring FDS, PTR, both depths and the receive request back to reset values.
  task automatic s_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FDS, 32'h0, OK);
    rd(PTR, 32'h0, OK);
    check(32'(tx_depth), 32'(edfc_pkg::FIFO_SMALL));
    check(32'(rx_depth), 32'(edfc_pkg::FIFO_SMALL));
    check(32'(rx_req), 32'h0);
  endtask
  // Each FIFO error with the halt selection clear and then set.
  task automatic s_fifo();
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 2; k++) begin
        wr(DOC, s ? 32'h0000_0008 : 32'h0, OK);
        rd(DOC, s ? 32'h8 : 32'h0, OK);
        pulse(k ? 6'h04 : 6'h08, 1);
        check(32'(dma_run), 32'(s == 0));
      end
    end
    wr(DOC, 32'h0, OK);
    check(32'(dma_run), 32'h1);
  endtask
  // Address-error flag, then the NMI halt and its restart.
  task automatic s_flags();
    int n;
    pulse(6'h02, 1);
    rd(DOC, 32'h4, OK);
    wr(DOC, 32'h4, OK);
    rd(DOC, 32'h4, OK);
    wr(DOC, 32'h0, OK);
    rd(DOC, 32'h0, OK);
    pulse(6'h20, 4);
    for (n = 0; n < 10 && dma_run; n++) @(posedge aclk);
    check(32'(dma_run), 32'h0);
    rd(DOC, 32'h2, OK);
    wr(DOC, 32'h0, OK);
    check(32'(dma_run), 32'h1);
    rd(DOC, 32'h0, OK);
  endtask
  // Inputs start quiet; reset is held for eight cycles.
  initial begin
    aresetn = 1'b0;
    ev = 6'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    ptr_in = 32'h1234_5678;
    dly = 4'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FDS, 32'h0, OK);
    rd(RPC, 32'h0, OK);
    rd(DOC, 32'h0, OK);
    rd(PTR, 32'h0, OK);
    check(32'(tx_depth), 32'(edfc_pkg::FIFO_SMALL));
    check(32'(rx_depth), 32'(edfc_pkg::FIFO_SMALL));
    wr(FDS, 32'h0000_0101, OK);
    rd(FDS, 32'h0000_0101, OK);
    check(32'(tx_depth), 32'(edfc_pkg::FIFO_LARGE));
    check(32'(rx_depth), 32'(edfc_pkg::FIFO_LARGE));
    wr(RPC, 32'h1, OK);
    rd(RPC, 32'h1, OK);
    s_frame(1'b0, 4'h0);
    s_frame(1'b1, 4'h5);
    s_fifo();
    s_flags();
    pulse(6'h01, 1);
    rd(PTR, 32'h1234_5678, OK);
    wr(PTR, 32'h0, OK);
    rd(PTR, 32'h1234_5678, OK);
    s_reset();
    wr(8'h14, 32'h1, ERR);
    rd(8'h14, 32'h0, ERR);
    final_report();
  end
endmodule
